// ===== verilog/ctf_pkg.sv
`default_nettype none
package ctf_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_PRESC = 8'h08;
  localparam logic [7:0] OFS_LINK = 8'h0c;
  localparam logic [7:0] OFS_STEP = 8'h10;
  // control field positions
  localparam int C_EN = 0;
  localparam int C_TSEL = 1;
  localparam int C_MODE = 2;
  localparam int C_THR = 4;
  localparam int C_DEPTH = 7;
  localparam int C_OWM = 10;
  localparam int C_IE = 11;
  localparam int C_SRC = 15;
  localparam int C_DIV10 = 16;
  localparam int C_IVAL = 24;
  // status field positions
  localparam int S_EMPTY = 8;
  localparam int S_FULL = 9;
  localparam int S_FLAG = 16;
  // link field positions
  localparam int L_EN = 8;
  // flag indices
  localparam int F_RX = 0;
  localparam int F_FULL = 1;
  localparam int F_TXC = 2;
  localparam int F_ONE = 3;
  // mode codes
  localparam logic [1:0] MODE_RX = 2'h0;
  localparam logic [1:0] MODE_TX = 2'h1;
  localparam logic [1:0] MODE_GW = 2'h2;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] PRESC_RST = 16'h0001;
  // prescaler period factors
  localparam int PRE_MUL = 2;
  localparam int TEN_MUL = 10;
  // message count selected by the depth code
  function automatic logic [7:0] depth_of(input logic [2:0] code);
    logic [7:0] d;
    d = 8'h00;
    unique case (code)
      3'h0: d = 8'h00;
      3'h1: d = 8'h04;
      3'h2: d = 8'h08;
      3'h3: d = 8'h10;
      3'h4: d = 8'h20;
      3'h5: d = 8'h30;
      3'h6: d = 8'h40;
      3'h7: d = 8'h80;
    endcase
    return d;
  endfunction : depth_of
endpackage : ctf_pkg
`default_nettype wire

// ===== verilog/ctf_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ctf_interval_timer #(
  parameter int PRE_W = 16,
  parameter int IVAL_W = 8
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic src_bit_i,
  input wire logic div_ten_i,
  input wire logic [PRE_W-1:0] prescaler_i,
  input wire logic [IVAL_W-1:0] interval_i,
  input wire logic bit_tick_i,
  output logic busy_o
);
  localparam int LIM_W = PRE_W + 5;
  initial begin
    if (PRE_W < 1 || IVAL_W < 1) $error("timer widths must be positive");
  end
  logic [LIM_W-1:0] pre_reg;
  logic [IVAL_W-1:0] left_reg;
  logic [LIM_W-1:0] limit;
  logic tick;
  // pclk periods per count: 2*a, or 2*a*10; a zero prescaler gives 2 periods, with or without the times-ten factor
  always_comb begin
    limit = LIM_W'(prescaler_i) * LIM_W'(ctf_pkg::PRE_MUL);
    if (div_ten_i) begin
      limit = LIM_W'(limit * LIM_W'(ctf_pkg::TEN_MUL)); // RULE9
    end
    if (limit == '0) begin
      limit = LIM_W'(ctf_pkg::PRE_MUL);
    end
  end
  // count source: bit clock or divided pclk; >= ends a count left above a lowered limit
  assign tick = src_bit_i ? bit_tick_i : (pre_reg >= limit - LIM_W'(1)); // RULE10 RULE8
  // prescale counter, restarted on each interval start
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_reg <= '0;
    end else if (start_i || tick || !busy_o) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + LIM_W'(1);
    end
  end
  // interval countdown of the setting value
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_reg <= '0;
      busy_o <= 1'b0;
    end else if (start_i) begin
      left_reg <= interval_i; // RULE11
      busy_o <= (interval_i != '0);
    end else if (busy_o && tick) begin
      left_reg <= left_reg - IVAL_W'(1);
      busy_o <= (left_reg != IVAL_W'(1));
    end
  end
  pre_bound_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE8
    src_bit_i || !$stable(src_bit_i) || !$stable(limit) || pre_reg < limit)
    else $error("prescale count passed its limit");
endmodule : ctf_interval_timer
`default_nettype wire

// ===== verilog/ctf_fifo_control.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE1] receive mode full flag when all slots used
// [RULE2] select low: complete flag when fifo empties; code sets it in transmit mode only, not when a gateway fifo empties
// [RULE3] select high: complete flag every transmission; code sets it in transmit mode only, not on gateway transmissions
// [RULE4] one-frame flag on every transmitted frame; code sets it in transmit mode only, not on gateway frames
// [RULE5] software avoids 1/8 threshold at depth four
// [RULE6] modes receive, transmit and gateway
// [RULE7] interval timer only in transmit or gateway
// [RULE8] code 00: period 2 times prescaler pclk
// [RULE9] code 10: period ten times longer
// [RULE10] source low bit set: nominal bit clock
// [RULE11] eight-bit interval multiplies the count period
// [RULE12] sixteen-bit global prescaler shared by fifos
// [RULE13] buffer link valid only transmit or gateway
// [RULE14] software keeps linked buffer out of queues
// [RULE15] software links one fifo per buffer
// [RULE16] gateway full: overwrite or drop per bit
// [RULE17] overwrite bit clear: drop incoming message
// [RULE18] overwrite bit set: replace oldest entry
// [RULE19] receive flag at chosen eighth fill level
// [RULE20] depth 0,4,8,16,32,48,64,128 messages
// [RULE21] hold next transmission until interval elapses
// [RULE22] sticky flags, enabled ones request interrupt
module ctf_fifo_control #(
  parameter int PRE_W = 16,
  parameter int IVAL_W = 8,
  parameter int LINK_W = 6
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic msg_in_i,
  input wire logic tx_done_i,
  input wire logic bit_tick_i,
  output logic tx_req_o,
  output logic msg_stored_o,
  output logic msg_dropped_o,
  output logic [6:0] wr_slot_o,
  output logic [6:0] rd_slot_o,
  output logic link_valid_o,
  output logic [LINK_W-1:0] link_buf_o,
  output logic irq_o
);
  initial begin
    if (PRE_W != 16 || IVAL_W != 8 || LINK_W < 1 || LINK_W > 8) begin
      $error("unsupported field widths");
    end
  end
  logic [31:0] ctrl_reg;
  logic [PRE_W-1:0] presc_reg;
  logic [LINK_W:0] link_reg;
  logic [3:0] flag_reg;
  logic [3:0] flag_next;
  logic [7:0] count_reg;
  logic [6:0] wr_reg;
  logic [6:0] rd_reg;
  logic ap_valid_reg;
  logic ap_write_reg;
  logic [7:0] ap_addr_reg;
  logic [31:0] rdata;
  logic [1:0] mode;
  logic mode_rx;
  logic mode_tx;
  logic mode_gw;
  logic active;
  logic [7:0] depth;
  logic full;
  logic empty;
  logic wr_step;
  logic push_req;
  logic pop_req;
  logic tx_pop;
  logic do_pop;
  logic do_push;
  logic ow_pop;
  logic [7:0] count_next;
  logic [11:0] fill_x8;
  logic [11:0] thr_lvl;
  logic timer_busy;
  logic [3:0] clr;
  // configuration decode
  assign mode = ctrl_reg[ctf_pkg::C_MODE +: 2];
  assign active = ctrl_reg[ctf_pkg::C_EN] && (depth != 8'h00); // RULE20
  assign mode_rx = active && (mode == ctf_pkg::MODE_RX); // RULE6
  assign mode_tx = active && (mode == ctf_pkg::MODE_TX); // RULE6
  assign mode_gw = active && (mode == ctf_pkg::MODE_GW); // RULE6
  assign depth = ctf_pkg::depth_of(ctrl_reg[ctf_pkg::C_DEPTH +: 3]); // RULE20
  assign full = (count_reg == depth);
  assign empty = (count_reg == 8'h00);
  // bus data-phase write strobe
  assign wr_step = ap_valid_reg && ap_write_reg && (ap_addr_reg == ctf_pkg::OFS_STEP);
  // queue movements: engine stores, software steps, engine transmits
  assign push_req = (msg_in_i && (mode_rx || mode_gw)) || (wr_step && mode_tx);
  assign tx_pop = tx_done_i && (mode_tx || mode_gw) && !empty;
  assign pop_req = tx_pop || (wr_step && mode_rx);
  assign do_pop = pop_req && !empty;
  assign ow_pop = push_req && full && !do_pop && mode_gw
    && ctrl_reg[ctf_pkg::C_OWM]; // RULE16 RULE18
  assign do_push = push_req && (!full || do_pop || ow_pop); // RULE17
  // occupancy after this cycle
  always_comb begin
    count_next = count_reg;
    if (do_push && !do_pop && !ow_pop) begin
      count_next = count_reg + 8'h01;
    end else if (do_pop && !do_push) begin
      count_next = count_reg - 8'h01;
    end
  end
  // fill level test: count*8 against (code+1)*depth
  assign fill_x8 = {1'b0, count_next, 3'h0};
  assign thr_lvl = 12'({1'b0, ctrl_reg[ctf_pkg::C_THR +: 3]} + 4'h1) * 12'(depth); // RULE19
  // address phase capture and registered read data
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
      hrdata_o <= 32'h0000_0000;
    end else if (hready_i) begin
      ap_valid_reg <= hsel_i && htrans_i[1];
      ap_write_reg <= hwrite_i;
      ap_addr_reg <= haddr_i;
      hrdata_o <= (hsel_i && htrans_i[1] && !hwrite_i) ? rdata : 32'h0000_0000;
    end
  end
  // zero wait state, always okay
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end
  // read mux; unmapped offsets read zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (haddr_i)
      ctf_pkg::OFS_CTRL: rdata = ctrl_reg;
      ctf_pkg::OFS_STAT: begin
        rdata[7:0] = count_reg;
        rdata[ctf_pkg::S_EMPTY] = empty;
        rdata[ctf_pkg::S_FULL] = full;
        rdata[ctf_pkg::S_FLAG +: 4] = flag_reg;
      end
      ctf_pkg::OFS_PRESC: rdata[PRE_W-1:0] = presc_reg;
      ctf_pkg::OFS_LINK: begin
        rdata[LINK_W-1:0] = link_reg[LINK_W-1:0];
        rdata[ctf_pkg::L_EN] = link_reg[LINK_W];
      end
      default: rdata = 32'h0000_0000;
    endcase
  end
  // configuration registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= ctf_pkg::CTRL_RST;
      presc_reg <= ctf_pkg::PRESC_RST;
      link_reg <= '0;
    end else if (ap_valid_reg && ap_write_reg) begin
      unique case (ap_addr_reg)
        ctf_pkg::OFS_CTRL: ctrl_reg <= hwdata_i;
        ctf_pkg::OFS_PRESC: presc_reg <= hwdata_i[PRE_W-1:0]; // RULE12
        ctf_pkg::OFS_LINK: link_reg <= {hwdata_i[ctf_pkg::L_EN], hwdata_i[LINK_W-1:0]};
        default: ;
      endcase
    end
  end
  // write-one-to-clear mask from the status register
  assign clr = (ap_valid_reg && ap_write_reg && ap_addr_reg == ctf_pkg::OFS_STAT)
    ? hwdata_i[ctf_pkg::S_FLAG +: 4] : 4'h0;
  // sticky event flags, a new event beats a clear
  always_comb begin
    flag_next = flag_reg & ~clr; // RULE22
    if (mode_rx && do_push && fill_x8 >= thr_lvl) begin
      flag_next[ctf_pkg::F_RX] = 1'b1; // RULE19
    end
    if (mode_rx && do_push && count_next == depth) begin
      flag_next[ctf_pkg::F_FULL] = 1'b1; // RULE1
    end
    if (mode_tx && tx_pop) begin
      flag_next[ctf_pkg::F_ONE] = 1'b1; // RULE4
      if (ctrl_reg[ctf_pkg::C_TSEL] || count_next == 8'h00) begin
        flag_next[ctf_pkg::F_TXC] = 1'b1; // RULE2 RULE3
      end
    end
  end
  // flags and interrupt request
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_reg <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      irq_o <= |(flag_next & ctrl_reg[ctf_pkg::C_IE +: 4]); // RULE22
    end
  end
  // slot pointers and occupancy; a disabled fifo is emptied
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= 8'h00;
      wr_reg <= 7'h00;
      rd_reg <= 7'h00;
    end else if (!active) begin
      count_reg <= 8'h00;
      wr_reg <= 7'h00;
      rd_reg <= 7'h00;
    end else begin
      count_reg <= count_next;
      if (do_push) begin
        wr_reg <= (8'({1'b0, wr_reg}) == depth - 8'h01) ? 7'h00 : wr_reg + 7'h01;
      end
      if (do_pop || ow_pop) begin
        rd_reg <= (8'({1'b0, rd_reg}) == depth - 8'h01) ? 7'h00 : rd_reg + 7'h01; // RULE18
      end
    end
  end
  // transmission pacing
  ctf_interval_timer #(
    .PRE_W(PRE_W),
    .IVAL_W(IVAL_W)
  ) u_timer (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .start_i(tx_pop), // RULE7 RULE21
    .src_bit_i(ctrl_reg[ctf_pkg::C_SRC]), // RULE10
    .div_ten_i(ctrl_reg[ctf_pkg::C_DIV10]), // RULE9
    .prescaler_i(presc_reg), // RULE12
    .interval_i(ctrl_reg[ctf_pkg::C_IVAL +: IVAL_W]), // RULE11
    .bit_tick_i(bit_tick_i),
    .busy_o(timer_busy)
  );
  // engine side outputs
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_req_o <= 1'b0;
      msg_stored_o <= 1'b0;
      msg_dropped_o <= 1'b0;
      wr_slot_o <= 7'h00;
      rd_slot_o <= 7'h00;
      link_valid_o <= 1'b0;
      link_buf_o <= '0;
    end else begin
      tx_req_o <= (mode_tx || mode_gw) && (count_next != 8'h00)
        && !timer_busy && !tx_done_i; // RULE7 RULE21
      msg_stored_o <= do_push;
      msg_dropped_o <= push_req && !do_push; // RULE17
      wr_slot_o <= wr_reg;
      rd_slot_o <= rd_reg;
      link_valid_o <= link_reg[LINK_W] && (mode_tx || mode_gw); // RULE13
      link_buf_o <= link_reg[LINK_W-1:0];
    end
  end
  rx_full_flag_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE1
    mode_rx && do_push && !do_pop && count_reg == depth - 8'h01 |=> flag_reg[ctf_pkg::F_FULL])
    else $error("full flag missed");
  txc_empty_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE2
    mode_tx && !ctrl_reg[ctf_pkg::C_TSEL] && tx_pop && count_reg == 8'h02 && !do_push
    |=> !$rose(flag_reg[ctf_pkg::F_TXC])) else $error("complete flag before empty");
  txc_each_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE3
    mode_tx && ctrl_reg[ctf_pkg::C_TSEL] && tx_pop |=> flag_reg[ctf_pkg::F_TXC])
    else $error("complete flag missed");
  one_frame_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE4
    mode_tx && tx_pop |=> flag_reg[ctf_pkg::F_ONE] ##1 irq_o || !ctrl_reg[ctf_pkg::C_IE + 3]
    || $past(clr[ctf_pkg::F_ONE])) else $error("one-frame flag lost");
  rx_no_tx_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE7
    $past(mode_rx) && mode_rx |-> !tx_req_o) else $error("transmit request in receive mode");
  link_mode_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE13
    link_valid_o |-> $past(mode_tx || mode_gw)) else $error("link valid outside tx modes");
  drop_keep_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE17
    mode_gw && full && push_req && !do_pop && !ctrl_reg[ctf_pkg::C_OWM]
    |=> $stable(count_reg) && $stable(wr_reg) && $stable(rd_reg) && msg_dropped_o)
    else $error("message not dropped");
  overwrite_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE18
    mode_gw && full && push_req && !do_pop && ctrl_reg[ctf_pkg::C_OWM]
    |=> rd_reg != $past(rd_reg) && $stable(count_reg) && msg_stored_o)
    else $error("oldest entry not replaced");
  pacing_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE21
    tx_pop && !ctrl_reg[ctf_pkg::C_SRC] && ctrl_reg[ctf_pkg::C_IVAL +: IVAL_W] != '0
    |=> !tx_req_o [*2]) else $error("transmission not held off");
  irq_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE22
    irq_o == |(flag_reg & $past(ctrl_reg[ctf_pkg::C_IE +: 4])))
    else $error("interrupt not matching enabled flags");
endmodule : ctf_fifo_control
`default_nettype wire

// ===== tb/ctf_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctf_engine_model #(
  parameter int BIT_CYC = 5
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic tx_req_i,
  input wire logic auto_i,
  input wire logic [1:0] gap_i,
  input wire logic rx_go_i,
  output logic tx_done_o,
  output logic msg_in_o,
  output logic bit_tick_o
);
  logic [3:0] bit_cnt;
  logic [3:0] wait_cnt;
  // nominal bit clock, one tick every BIT_CYC cycles
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt <= 4'h0;
      bit_tick_o <= 1'b0;
    end else begin
      bit_tick_o <= (bit_cnt == 4'(BIT_CYC - 1));
      bit_cnt <= (bit_cnt == 4'(BIT_CYC - 1)) ? 4'h0 : bit_cnt + 4'h1;
    end
  end
  // sends a frame once the request has stood gap cycles, slow or prompt
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_cnt <= 4'h0;
      tx_done_o <= 1'b0;
      msg_in_o <= 1'b0;
    end else begin
      tx_done_o <= auto_i && tx_req_i && !tx_done_o && (wait_cnt >= {2'h0, gap_i});
      wait_cnt <= (!tx_req_i || tx_done_o) ? 4'h0 : wait_cnt + 4'h1;
      msg_in_o <= rx_go_i;
    end
  end
endmodule : ctf_engine_model
`default_nettype wire

// ===== tb/tb_ctf_fifo_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ctf_fifo_control;
  localparam int BIT_CYC = 5;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, tx_req, stored, dropped, link_v, irq, tx_done, msg_in, tick;
  logic auto = 1'b0;
  logic rx_go = 1'b0;
  logic [6:0] wr_slot, rd_slot, rs;
  logic [5:0] link_buf, lb;
  logic [7:0] r = 8'h42;
  logic [1:0] gap = 2'h0;
  int n_mismatch = 0, checks_done = 0, n_store = 0, n_drop = 0, hcnt = 0, hgap = 0;
  int e, lo, a, b, ns, nd;
  always #50 clock_i = ~clock_i;
  ctf_fifo_control i_ctf_fifo_control (.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .msg_in_i(msg_in), .tx_done_i(tx_done), .bit_tick_i(tick), .tx_req_o(tx_req),
    .msg_stored_o(stored), .msg_dropped_o(dropped), .wr_slot_o(wr_slot), .rd_slot_o(rd_slot),
    .link_valid_o(link_v), .link_buf_o(link_buf), .irq_o(irq));
  ctf_engine_model #(.BIT_CYC(BIT_CYC)) i_ctf_engine_model (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .tx_req_i(tx_req), .auto_i(auto), .gap_i(gap), .rx_go_i(rx_go),
    .tx_done_o(tx_done), .msg_in_o(msg_in), .bit_tick_o(tick));
  // pulse counters and holdoff length from a finished frame to the next request
  always @(posedge clock_i) begin
    n_store += int'(stored);
    n_drop += int'(dropped);
    if (tx_done === 1'b1) hcnt = 0;
    else if (tx_req !== 1'b1) hcnt++;
    else if (hcnt > 0) begin
      hgap = hcnt;
      hcnt = 0;
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // control word: threshold 4/8, depth code four messages, all sources enabled
  function automatic logic [31:0] ctrl(input logic [1:0] m, input logic ts, sr, dt, ow,
                                       input logic [7:0] iv);
    return 32'h1 | ({31'h0, ts} << ctf_pkg::C_TSEL) | ({30'h0, m} << ctf_pkg::C_MODE)
      | (32'h3 << ctf_pkg::C_THR) | (32'h1 << ctf_pkg::C_DEPTH) | ({31'h0, ow} << ctf_pkg::C_OWM)
      | (32'hf << ctf_pkg::C_IE) | ({31'h0, sr} << ctf_pkg::C_SRC)
      | ({31'h0, dt} << ctf_pkg::C_DIV10) | ({24'h0, iv} << ctf_pkg::C_IVAL);
  endfunction : ctrl
  function automatic logic [31:0] rx_stat(input int n);
    return 32'(n) | (n >= 2 ? 32'h1_0000 : 32'h0) | (n == 4 ? 32'h2_0200 : 32'h0);
  endfunction : rx_stat
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= wr;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("response okay", {31'h0, hresp}, 32'h0);
  endtask : bus
  task automatic msg();
    rx_go <= 1'b1;
    @(posedge clock_i);
    rx_go <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask : msg
  task automatic wait_done();
    for (int t = 0; t < 3000 && tx_done !== 1'b1; t++) @(posedge clock_i);
    if (tx_done !== 1'b1) n_mismatch++;
    auto <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask : wait_done
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // watchdog
  initial begin
    #5000000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    bus(1'b0, ctf_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", rd, ctf_pkg::CTRL_RST);
    bus(1'b0, ctf_pkg::OFS_PRESC, 32'h0);
    chk("prescaler reset", rd, 32'(ctf_pkg::PRESC_RST));
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    // receive mode, threshold other than 1/8 at depth four
    r = lfsr(r);
    lb = r[5:0];
    bus(1'b1, ctf_pkg::OFS_LINK, 32'h100 | 32'(lb));
    bus(1'b1, ctf_pkg::OFS_CTRL, ctrl(ctf_pkg::MODE_RX, 1'b0, 1'b0, 1'b0, 1'b0, 8'h3));
    for (int i = 1; i <= 4; i++) begin
      msg();
      bus(1'b0, ctf_pkg::OFS_STAT, 32'h0);
      chk("rx status", rd, rx_stat(i));
    end
    chk("rx full irq", {31'h0, irq}, 32'h1);
    chk("link in rx", {31'h0, link_v}, 32'h0);
    nd = n_drop;
    msg();
    chk("rx drop", 32'(n_drop - nd), 32'h1);
    chk("rx no request", {31'h0, tx_req}, 32'h0);
    bus(1'b1, ctf_pkg::OFS_STAT, 32'hf_0000);
    bus(1'b0, ctf_pkg::OFS_STAT, 32'h0);
    chk("flags cleared", rd, 32'h204);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    bus(1'b1, ctf_pkg::OFS_STEP, 32'h0);
    bus(1'b0, ctf_pkg::OFS_STAT, 32'h0);
    chk("rx pop", rd, 32'h3);
    // transmit mode: pclk, pclk/10 and bit clock sources, both timing selects
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, ctf_pkg::OFS_CTRL, 32'h0); // off: empties the queue
      r = lfsr(r);
      a = k == 1 ? 1 : int'(r[1:0]) + 1;
      b = int'(r[4:2]) + 1;
      gap <= r[7:6];
      bus(1'b1, ctf_pkg::OFS_PRESC, 32'(a));
      bus(1'b1, ctf_pkg::OFS_CTRL, ctrl(ctf_pkg::MODE_TX, k == 1, k == 2, k == 1, 1'b0, 8'(b)));
      bus(1'b1, ctf_pkg::OFS_STAT, 32'hf_0000);
      bus(1'b1, ctf_pkg::OFS_STEP, 32'h0);
      bus(1'b1, ctf_pkg::OFS_STEP, 32'h0);
      chk("link valid", {25'h0, link_v, link_buf}, {25'h0, 1'b1, lb});
      auto <= 1'b1;
      wait_done();
      bus(1'b0, ctf_pkg::OFS_STAT, 32'h0);
      chk("first frame", rd, 32'h8_0001 | (k == 1 ? 32'h4_0000 : 32'h0));
      auto <= 1'b1;
      wait_done();
      bus(1'b0, ctf_pkg::OFS_STAT, 32'h0);
      chk("last frame", rd, 32'hc_0100);
      e = k == 2 ? b * BIT_CYC : ctf_pkg::PRE_MUL * a * b * (k == 1 ? ctf_pkg::TEN_MUL : 1);
      lo = k == 2 ? e - BIT_CYC : e - 1;
      chk("holdoff", {31'h0, hgap >= lo && hgap <= e + 3}, 32'h1);
    end
    // gateway mode: drop when full, then overwrite the oldest
    bus(1'b1, ctf_pkg::OFS_CTRL, ctrl(ctf_pkg::MODE_GW, 1'b0, 1'b0, 1'b0, 1'b0, 8'h0));
    nd = n_drop;
    repeat (5) msg();
    chk("link in gw", {31'h0, link_v}, 32'h1);
    chk("gw drop", 32'(n_drop - nd), 32'h1);
    bus(1'b0, ctf_pkg::OFS_STAT, 32'h0);
    chk("gw full", rd & 32'h3ff, 32'h204);
    rs = rd_slot;
    ns = n_store;
    bus(1'b1, ctf_pkg::OFS_CTRL, ctrl(ctf_pkg::MODE_GW, 1'b0, 1'b0, 1'b0, 1'b1, 8'h0));
    msg();
    chk("gw overwrite", {25'h0, rd_slot}, 32'((rs + 7'h1) % 7'h4));
    chk("gw stored", 32'(n_store - ns), 32'h1);
    chk("gw write slot", {25'h0, wr_slot}, 32'((rs + 7'h1) % 7'h4));
    bus(1'b0, ctf_pkg::OFS_STAT, 32'h0);
    chk("gw count", rd & 32'hff, 32'h4);
    results();
  end
endmodule : tb_ctf_fifo_control
`default_nettype wire
